/* File: cgp_defines.vh */
// register map, field positions and timing constants for the clock generator
`ifndef CGP_DEFINES_VH
`define CGP_DEFINES_VH
// register byte addresses (word aligned)
`define CGP_ADDR_LOOPCSR 12'h000
`define CGP_ADDR_CORESEL 12'h004
`define CGP_ADDR_MULT 12'h008
`define CGP_ADDR_REFDIV 12'h00C
`define CGP_ADDR_DIV1 12'h010
`define CGP_ADDR_DIV2 12'h014
`define CGP_ADDR_DIV3 12'h018
`define CGP_ADDR_MODE 12'h01C
`define CGP_ADDR_IDLE 12'h020
// loop control/status fields
`define CGP_CSR_EN 0
`define CGP_CSR_RST 3
`define CGP_CSR_PWRDN 2
`define CGP_CSR_LOCK 5
`define CGP_CSR_STABLE 6
// writable loop control bits: enable, power-down, loop reset
`define CGP_CSR_WMASK 4'hD
// reset values
`define CGP_CSR_RESET 4'h8
`define CGP_CORESEL_RESET 4'hB
`define CGP_MULT_RESET 4'h2
`define CGP_REFDIV_RESET 5'h00
`define CGP_POSTDIV_RESET 2'h3
// post-divider codes: 0 -> /1, 1 -> /2, others -> /4
`define CGP_PD_DIV1 2'h0
`define CGP_PD_DIV2 2'h1
// multiplier limits
`define CGP_MULT_MIN 4'h2
// oscillator stabilization count
`define CGP_OSC_STAB_CYCLES 41032
`define CGP_OSC_CNT_W 16
// modelled loop lock time, reference cycles
`define CGP_LOCK_CYCLES 8'h40
`endif

/* File: cgp_clock_gen.v */
// system clock generator: source select, loop model, post-dividers, osc power
//
// Summary of operation
// [RULE1] strap at reset picks oscillator or pin
// [RULE2] loop divides by 1..32, multiplies 2..15
// [RULE3] loop enable bit picks loop or bypass
// [RULE4] reset leaves generator in bypass mode
// [RULE5] oscillator source: power down when idle
// [RULE6] pin source: power down immediately
// [RULE7] count 41032 cycles of oscillator stabilization
// [RULE8] hold execution until stabilization ends
// [RULE9] resume execution when wake count ends
// [RULE10] software keeps loop frequencies in range
// [RULE11] software keeps memory clock within limits
// [RULE12] core select field defaults to 1011b
// [RULE13] fast group from divider one, /4 default
// [RULE14] slow group from divider two, /4 default
// [RULE15] software keeps slow below fast group
// [RULE16] memory group from divider three, /4 default
// [RULE17] software keeps memory below fast group
// [RULE18] lock flag bit 5 shows loop lock
// [RULE19] stable flag bit 6 shows count done
// [RULE20] clock switching and divider changes glitch free
`timescale 1ns/1ps
`include "cgp_defines.vh"
module cgp_clock_gen #(
	parameter STAB_CYCLES = `CGP_OSC_STAB_CYCLES
) (
	input wire ref_clk,
	input wire reset,
	input wire boot_strap_pin,
	input wire clockgen_idle_flag,
	input wire counter_disable,
	input wire test_mode,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	output wire osc_powerdown,
	output wire cpu_run,
	output wire loop_out_tick,
	output wire core_group_tick,
	output wire fast_periph_tick,
	output wire slow_periph_tick,
	output wire ext_memory_tick
);
	// divider code to ratio minus one (0->0, 1->1, else 3)
	function [1:0] cgp_pd_last;
		input [1:0] code;
		begin
			if (code == `CGP_PD_DIV1) begin
				cgp_pd_last = 2'h0;
			end else if (code == `CGP_PD_DIV2) begin
				cgp_pd_last = 2'h1;
			end else begin
				cgp_pd_last = 2'h3;
			end
		end
	endfunction

	localparam ST_STAB = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_PWRDN = 2'h2;
	localparam integer STAB_LAST_I = STAB_CYCLES - 1;
	localparam [`CGP_OSC_CNT_W-1:0] STAB_LAST = STAB_LAST_I[`CGP_OSC_CNT_W-1:0];

	// software visible registers
	reg [3:0] csr_ff; // bit0 loop enable, bit2 power-down, bit3 loop reset
	reg [3:0] coresel_ff;
	reg [3:0] mult_ff;
	reg [4:0] refdiv_ff;
	reg [1:0] div1_ff;
	reg [1:0] div2_ff;
	reg [1:0] div3_ff;
	reg src_sel_ff; // input source select bit
	// oscillator and execution state
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [`CGP_OSC_CNT_W-1:0] stab_cnt_ff;
	reg [`CGP_OSC_CNT_W-1:0] nxt_stab_cnt;
	reg strap_seen_ff; // first cycle after reset release
	reg stab_done_ff;
	reg run_ff;
	// loop model state
	reg [4:0] ref_cnt_ff;
	reg [3:0] mul_cnt_ff;
	reg [7:0] lock_cnt_ff;
	reg lock_ff;
	reg loop_tick_ff;
	reg sel_loop_ff; // applied bypass/loop choice
	// post-divider counters and applied ratios
	reg [1:0] pd1_cnt_ff;
	reg [1:0] pd2_cnt_ff;
	reg [1:0] pd3_cnt_ff;
	reg [1:0] pd1_last_ff;
	reg [1:0] pd2_last_ff;
	reg [1:0] pd3_last_ff;

	wire wr_en = psel & penable & pwrite;
	wire ref_tick = 1'b1; // one reference cycle per ref_clk edge
	wire mapped = (paddr == `CGP_ADDR_LOOPCSR) | (paddr == `CGP_ADDR_CORESEL) |
		(paddr == `CGP_ADDR_MULT) | (paddr == `CGP_ADDR_REFDIV) |
		(paddr == `CGP_ADDR_DIV1) | (paddr == `CGP_ADDR_DIV2) |
		(paddr == `CGP_ADDR_DIV3) | (paddr == `CGP_ADDR_MODE) |
		(paddr == `CGP_ADDR_IDLE);
	wire stable_flag;
	wire src_tick;
	wire core_tick;

	// apb: zero wait states, unmapped gives slave error
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// register writes
	always @(posedge ref_clk) begin
		if (reset) begin
			// [RULE4] bypass after reset
			csr_ff <= `CGP_CSR_RESET;
			// [RULE12] core select default
			coresel_ff <= `CGP_CORESEL_RESET;
			mult_ff <= `CGP_MULT_RESET;
			refdiv_ff <= `CGP_REFDIV_RESET;
			// [RULE13] fast divider /4
			div1_ff <= `CGP_POSTDIV_RESET;
			// [RULE14] slow divider /4
			div2_ff <= `CGP_POSTDIV_RESET;
			// [RULE16] memory divider /4
			div3_ff <= `CGP_POSTDIV_RESET;
		end else if (wr_en) begin
			case (paddr)
				`CGP_ADDR_LOOPCSR: begin
					csr_ff <= pwdata[3:0] & `CGP_CSR_WMASK;
				end
				`CGP_ADDR_CORESEL: begin
					coresel_ff <= pwdata[3:0];
				end
				`CGP_ADDR_MULT: begin
					// clamp below the smallest legal multiplier
					mult_ff <= (pwdata[3:0] < `CGP_MULT_MIN) ? `CGP_MULT_MIN : pwdata[3:0];
				end
				`CGP_ADDR_REFDIV: begin
					refdiv_ff <= pwdata[4:0];
				end
				`CGP_ADDR_DIV1: begin
					div1_ff <= pwdata[1:0];
				end
				`CGP_ADDR_DIV2: begin
					div2_ff <= pwdata[1:0];
				end
				`CGP_ADDR_DIV3: begin
					div3_ff <= pwdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// strap capture one cycle after release, never under reset itself
	always @(posedge ref_clk) begin
		if (reset) begin
			strap_seen_ff <= 1'b0;
			src_sel_ff <= 1'b0;
		end else if (!strap_seen_ff) begin
			strap_seen_ff <= 1'b1;
			// [RULE1] strap picks source
			src_sel_ff <= boot_strap_pin;
		end
	end

	// oscillator power and execution state machine
	always @* begin
		nxt_state = state_ff;
		nxt_stab_cnt = stab_cnt_ff;
		case (state_ff)
			ST_STAB: begin
				// [RULE7] stabilization count
				if (stab_cnt_ff == STAB_LAST) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_stab_cnt = stab_cnt_ff + 1'b1;
				end
			end
			ST_RUN: begin
				// [RULE5] oscillator source waits for idle
				if (csr_ff[`CGP_CSR_PWRDN] && (src_sel_ff || clockgen_idle_flag)) begin
					// [RULE6] pin source goes at once
					nxt_state = ST_PWRDN;
				end
			end
			ST_PWRDN: begin
				// wake when software clears power-down
				if (!csr_ff[`CGP_CSR_PWRDN]) begin
					nxt_state = ST_STAB;
					nxt_stab_cnt = {`CGP_OSC_CNT_W{1'b0}};
				end
			end
			default: begin
				nxt_state = ST_STAB;
			end
		endcase
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			state_ff <= ST_STAB;
			stab_cnt_ff <= {`CGP_OSC_CNT_W{1'b0}};
			stab_done_ff <= 1'b0;
			run_ff <= 1'b0;
		end else begin
			// strap high at reset skips the oscillator count
			if (strap_seen_ff || !boot_strap_pin) begin
				state_ff <= nxt_state;
			end else begin
				state_ff <= ST_RUN;
			end
			stab_cnt_ff <= nxt_stab_cnt;
			stab_done_ff <= (nxt_state != ST_STAB);
			// [RULE8] hold execution until stable
			// [RULE9] resume right after wake count
			run_ff <= (nxt_state == ST_RUN) && (strap_seen_ff || boot_strap_pin);
		end
	end

	// [RULE19] stable flag sources
	assign stable_flag = stab_done_ff | counter_disable | test_mode;
	assign osc_powerdown = (state_ff == ST_PWRDN);
	assign cpu_run = run_ff;

	// input clock is absent while the selected oscillator is off
	assign src_tick = ref_tick & ~((state_ff == ST_PWRDN) & ~src_sel_ff);

	// loop model: burst of mult ticks per refdiv+1 src ticks, a reload during a running burst is dropped
	always @(posedge ref_clk) begin
		if (reset || csr_ff[`CGP_CSR_RST]) begin
			ref_cnt_ff <= 5'h00;
			mul_cnt_ff <= 4'h0;
			lock_cnt_ff <= 8'h00;
			lock_ff <= 1'b0;
			loop_tick_ff <= 1'b0;
		end else begin
			loop_tick_ff <= 1'b0;
			if (src_tick) begin
				// [RULE2] reference divide
				if (ref_cnt_ff == refdiv_ff) begin
					ref_cnt_ff <= 5'h00;
					mul_cnt_ff <= mult_ff;
				end else begin
					ref_cnt_ff <= ref_cnt_ff + 5'h01;
				end
				// [RULE18] lock after settling
				if (lock_cnt_ff == `CGP_LOCK_CYCLES) begin
					lock_ff <= 1'b1;
				end else begin
					lock_cnt_ff <= lock_cnt_ff + 8'h01;
				end
			end
			// [RULE2] multiply as burst of ticks
			if (mul_cnt_ff != 4'h0) begin
				mul_cnt_ff <= mul_cnt_ff - 4'h1;
				loop_tick_ff <= 1'b1;
			end
		end
	end

	// [RULE20] switch bypass/loop only on a cycle without a loop tick
	always @(posedge ref_clk) begin
		if (reset) begin
			sel_loop_ff <= 1'b0;
		end else if (!loop_tick_ff && !src_tick) begin
			sel_loop_ff <= csr_ff[`CGP_CSR_EN];
		end else if (csr_ff[`CGP_CSR_EN] != sel_loop_ff && !loop_tick_ff) begin
			sel_loop_ff <= csr_ff[`CGP_CSR_EN];
		end
	end

	// [RULE3] loop or bypass output
	assign core_tick = sel_loop_ff ? loop_tick_ff : src_tick;
	assign loop_out_tick = loop_tick_ff;
	assign core_group_tick = core_tick;

	// post-dividers: new ratio taken only at a period boundary
	always @(posedge ref_clk) begin
		if (reset) begin
			pd1_cnt_ff <= 2'h0;
			pd2_cnt_ff <= 2'h0;
			pd3_cnt_ff <= 2'h0;
			pd1_last_ff <= cgp_pd_last(`CGP_POSTDIV_RESET);
			pd2_last_ff <= cgp_pd_last(`CGP_POSTDIV_RESET);
			pd3_last_ff <= cgp_pd_last(`CGP_POSTDIV_RESET);
		end else if (core_tick) begin
			// [RULE13] fast group divider
			if (pd1_cnt_ff >= pd1_last_ff) begin
				pd1_cnt_ff <= 2'h0;
				// [RULE20] ratio change at boundary
				pd1_last_ff <= cgp_pd_last(div1_ff);
			end else begin
				pd1_cnt_ff <= pd1_cnt_ff + 2'h1;
			end
			// [RULE14] slow group divider
			if (pd2_cnt_ff >= pd2_last_ff) begin
				pd2_cnt_ff <= 2'h0;
				pd2_last_ff <= cgp_pd_last(div2_ff);
			end else begin
				pd2_cnt_ff <= pd2_cnt_ff + 2'h1;
			end
			// [RULE16] memory group divider
			if (pd3_cnt_ff >= pd3_last_ff) begin
				pd3_cnt_ff <= 2'h0;
				pd3_last_ff <= cgp_pd_last(div3_ff);
			end else begin
				pd3_cnt_ff <= pd3_cnt_ff + 2'h1;
			end
		end
	end

	// group ticks fire on the last count of each period
	assign fast_periph_tick = core_tick & (pd1_cnt_ff >= pd1_last_ff);
	assign slow_periph_tick = core_tick & (pd2_cnt_ff >= pd2_last_ff);
	assign ext_memory_tick = core_tick & (pd3_cnt_ff >= pd3_last_ff);

	// read data loaded in the setup phase, so it stands from a flop in access
	always @(posedge ref_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= 32'h0000_0000;
			case (paddr)
				`CGP_ADDR_LOOPCSR: begin
					prdata[3:0] <= csr_ff;
					prdata[`CGP_CSR_LOCK] <= lock_ff;
					prdata[`CGP_CSR_STABLE] <= stable_flag;
				end
				`CGP_ADDR_CORESEL: begin
					prdata[3:0] <= coresel_ff;
				end
				`CGP_ADDR_MULT: begin
					prdata[3:0] <= mult_ff;
				end
				`CGP_ADDR_REFDIV: begin
					prdata[4:0] <= refdiv_ff;
				end
				`CGP_ADDR_DIV1: begin
					prdata[1:0] <= div1_ff;
				end
				`CGP_ADDR_DIV2: begin
					prdata[1:0] <= div2_ff;
				end
				`CGP_ADDR_DIV3: begin
					prdata[1:0] <= div3_ff;
				end
				`CGP_ADDR_MODE: begin
					prdata[0] <= src_sel_ff;
				end
				`CGP_ADDR_IDLE: begin
					prdata[1:0] <= state_ff;
					prdata[2] <= run_ff;
				end
				default: begin
					prdata <= 32'h0000_0000;
				end
			endcase
		end
	end
endmodule

/* File: cgp_checker_properties.sv */
// port checker for the clock generator
`timescale 1ns/1ps
module cgp_checker #(
	parameter STAB_CYCLES = 16
) (
	input wire ref_clk,
	input wire reset,
	input wire boot_strap_pin,
	input wire clockgen_idle_flag,
	input wire counter_disable,
	input wire test_mode,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire osc_powerdown,
	input wire cpu_run,
	input wire core_group_tick,
	input wire fast_periph_tick
);
	reg [16:0] halt_cnt_ff; // halted cycles since reset
	reg first_ff; // no run yet since reset
	reg pin_src_ff; // strap seen during reset
	wire acc = psel && penable;
	wire csr_rd = acc && !pwrite && paddr == 12'h000;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// helper registers, set up by reset: halt count cleared, first flag set, strap sampled
	always @(posedge ref_clk) begin
		if (reset) begin
			halt_cnt_ff <= 17'h0_0000;
			first_ff <= 1'b1;
			pin_src_ff <= boot_strap_pin;
		end else begin
			halt_cnt_ff <= halt_cnt_ff + {16'h0000, !cpu_run};
			first_ff <= first_ff && !cpu_run;
		end
	end
	chk_reset_halt: assert property (disable iff (1'b0) reset |=> !cpu_run)
		else $error("cpu_run high after reset edge");
	chk_pin_run: assert property ($fell(reset) && boot_strap_pin |-> ##[0:3] cpu_run)
		else $error("pin source start late");
	chk_stab_count: assert property (first_ff && !pin_src_ff && $rose(cpu_run) |->
		halt_cnt_ff >= STAB_CYCLES && halt_cnt_ff <= STAB_CYCLES + 4)
		else $error("stabilization count wrong");
	chk_idle_wait: assert property ($rose(osc_powerdown) && !pin_src_ff |->
		$past(clockgen_idle_flag)) else $error("oscillator off before idle");
	chk_stable_forced: assert property (csr_rd && (counter_disable || test_mode)
		|-> prdata[6]) else $error("stable flag not forced");
	chk_fast_aligned: assert property (fast_periph_tick |-> core_group_tick)
		else $error("fast tick without core tick");
	chk_csr_zero_bits: assert property (csr_rd |->
		prdata[31:7] == 25'h0 && !prdata[4] && !prdata[1]) else $error("csr spare bits set");
	chk_unmapped_err: assert property (acc && !pwrite && paddr > 12'h020 |->
		pslverr && prdata == 32'h0) else $error("unmapped read not refused");
	cover property ($rose(osc_powerdown));
	cover property ($rose(cpu_run));
	cover property (csr_rd && prdata[5]);
endmodule
bind cgp_clock_gen cgp_checker #(.STAB_CYCLES(STAB_CYCLES)) i_chk (.ref_clk, .reset,
	.boot_strap_pin, .clockgen_idle_flag, .counter_disable, .test_mode, .psel, .penable,
	.pwrite, .paddr, .prdata, .pslverr, .osc_powerdown, .cpu_run, .core_group_tick,
	.fast_periph_tick);

/* File: cgp_source_model.sv */
// far-side clock source: strap level and slow idle handshake
`timescale 1ns/1ps
module cgp_source_model #(
	parameter IDLE_LAG = 3
) (
	input wire ref_clk,
	input wire use_pin,
	input wire idle_req,
	output wire boot_strap_pin,
	output wire clockgen_idle_flag
);
	reg [3:0] lag_ff = 4'h0; // idle entry is never instant
	reg idle_ff = 1'b0;
	assign boot_strap_pin = use_pin;
	assign clockgen_idle_flag = idle_ff;
	// idle rises late, drops at once
	always @(posedge ref_clk) begin
		lag_ff <= idle_req ? lag_ff + 4'h1 : 4'h0;
		idle_ff <= idle_req && lag_ff >= IDLE_LAG;
	end
endmodule

/* File: clock_generator_pll_groups_bench.sv */
// self-checking bench for the clock generator
`timescale 1ns/1ps
module clock_generator_pll_groups_bench;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d, e; logic x;} cgp_row_t;
	reg ref_clk, reset, psel, penable, pwrite, use_pin, idle_req, cnt_dis, tmode, err;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd;
	wire strap, idle, pready, pslverr, osc_pd, cpu_run, loop_t, core_t;
	wire [2:0] grp_t; // memory, slow, fast ticks
	wire [31:0] prdata;
	cgp_row_t tbl [16];
	int error_cnt = 0, comparisons = 0, cyc = 0, i, d, n, m;
	cgp_clock_gen #(.STAB_CYCLES(16)) i_dut (.ref_clk(ref_clk), .reset(reset),
		.boot_strap_pin(strap), .clockgen_idle_flag(idle), .counter_disable(cnt_dis),
		.test_mode(tmode), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.osc_powerdown(osc_pd), .cpu_run(cpu_run), .loop_out_tick(loop_t),
		.core_group_tick(core_t), .fast_periph_tick(grp_t[0]),
		.slow_periph_tick(grp_t[1]), .ext_memory_tick(grp_t[2]));
	cgp_source_model i_src (.ref_clk(ref_clk), .use_pin(use_pin), .idle_req(idle_req),
		.boot_strap_pin(strap), .clockgen_idle_flag(idle));
	always #20 ref_clk = ~ref_clk;
	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge ref_clk);
		penable <= 1'b1;
		// wait ends once pready is sampled high, or at the hang guard if it never rises
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_run;
		n = 0;
		while (cpu_run !== 1'b1 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task report_and_stop;
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		ref_clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
		pwdata = 32'h0; use_pin = 0; idle_req = 0; cnt_dis = 0; tmode = 0;
		// reset values, ranges, refusal
		tbl = '{'{1'b0, 12'h000, 32'h0, 32'h48, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'hB, 1'b0},
			'{1'b0, 12'h008, 32'h0, 32'h2, 1'b0}, '{1'b0, 12'h00C, 32'h0, 32'h0, 1'b0},
			'{1'b0, 12'h010, 32'h0, 32'h3, 1'b0}, '{1'b0, 12'h014, 32'h0, 32'h3, 1'b0},
			'{1'b0, 12'h018, 32'h0, 32'h3, 1'b0}, '{1'b0, 12'h01C, 32'h0, 32'h0, 1'b0},
			'{1'b1, 12'h008, 32'hF, 32'h0, 1'b0}, '{1'b0, 12'h008, 32'h0, 32'hF, 1'b0},
			'{1'b1, 12'h00C, 32'h1F, 32'h0, 1'b0}, '{1'b0, 12'h00C, 32'h0, 32'h1F, 1'b0},
			'{1'b1, 12'h024, 32'h5, 32'h0, 1'b1}, '{1'b0, 12'h024, 32'h0, 32'h0, 1'b1},
			'{1'b1, 12'h008, 32'h1, 32'h0, 1'b0}, '{1'b0, 12'h008, 32'h0, 32'h2, 1'b0}};
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		wait_run;
		chk(cpu_run, 1'b1);
		for (i = 0; i < 16; i++) begin
			apb(tbl[i].w, tbl[i].a, tbl[i].d);
			if (!tbl[i].w) chk(rd, tbl[i].e);
			chk(err, tbl[i].x);
		end
		// fast group first at /1 so slower groups never overtake it
		apb(1'b1, 12'h010, 32'h0);
		for (d = 2; d >= 0; d--) begin
			for (m = 0; m < 3; m++) begin
				apb(1'b1, 12'h010 + 12'(4 * d), m);
				repeat (8) @(posedge ref_clk);
				n = 0;
				repeat (16) begin
					@(posedge ref_clk);
					n += grp_t[d];
				end
				chk(n, 16 >> m);
			end
		end
		apb(1'b1, 12'h00C, 32'h1);
		apb(1'b1, 12'h008, 32'h6);
		apb(1'b1, 12'h000, 32'h0);
		i = 0;
		do begin
			apb(1'b0, 12'h000, 32'h0);
			i++;
		end while (rd[5] !== 1'b1 && i < 100);
		chk(rd[5], 1'b1);
		apb(1'b1, 12'h000, 32'h1);
		repeat (16) @(posedge ref_clk);
		n = 0;
		m = 0;
		repeat (32) begin
			@(posedge ref_clk);
			n += core_t;
			m += loop_t;
		end
		chk(n, m);
		apb(1'b1, 12'h000, 32'h8);
		repeat (16) @(posedge ref_clk);
		n = 0;
		repeat (16) begin
			@(posedge ref_clk);
			n += core_t;
		end
		chk(n, 16);
		apb(1'b1, 12'h000, 32'hC);
		repeat (10) @(posedge ref_clk);
		chk(osc_pd, 1'b0);
		idle_req <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk(osc_pd, 1'b1);
		idle_req <= 1'b0;
		apb(1'b1, 12'h000, 32'h8);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd[6], 1'b0);
		// forcing inputs checked while the wake count still runs
		cnt_dis <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd[6], 1'b1);
		cnt_dis <= 1'b0;
		tmode <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd[6], 1'b1);
		tmode <= 1'b0;
		chk(cpu_run, 1'b0);
		wait_run;
		chk(cpu_run, 1'b1);
		// second reset, pin source
		use_pin <= 1'b1;
		reset <= 1'b1;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(cpu_run, 1'b1);
		apb(1'b0, 12'h01C, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h000, 32'hC);
		repeat (3) @(posedge ref_clk);
		chk(osc_pd, 1'b1);
		report_and_stop;
	end
endmodule
